// ===== hw/iord_space.sv
// Purpose: I/O register space of an 8-bit core: decode, bit access, flag clearing
// Assumes: One request per cycle, answer two edges after it is taken
// Notes:   Extended space 0x60..0xff is forwarded to an outside register bus
`timescale 1ns/100ps
`include "iord_map.svh"

module iord_space (
    // Clock and reset
    input  wire logic                      clock_i,
    input  wire logic                      reset_i,
    // Core request and answer
    input  wire iord_pkg::iord_req_t       req_i,
    output iord_pkg::iord_resp_t           resp_o,
    // Port pins
    input  wire logic [6:0][7:0]           pin_i,
    output logic      [6:0][7:0]           port_out_o,
    output logic      [6:0][7:0]           port_dir_o,
    // Peripheral flag events
    input  wire iord_pkg::iord_flag_set_t  flag_set_i,
    // Extended register bus
    output iord_pkg::iord_ext_t            ext_o,
    input  wire logic [7:0]                ext_rdata_i
);
    import iord_pkg::*;

    // ============================================================
    // Decode functions
    function automatic iord_dec_t io_decode(input logic [5:0] a);
        iord_dec_t d;
        d = '{kind: kind_none, mask: 8'h00};
        case (a)
            `IORD_PORT_A_INPUT_PINS, `IORD_PORT_B_INPUT_PINS,
            `IORD_PORT_C_INPUT_PINS, `IORD_PORT_D_INPUT_PINS,
            `IORD_PORT_E_INPUT_PINS, `IORD_PORT_F_INPUT_PINS: begin
                d = '{kind: kind_pin, mask: `IORD_MASK_FULL};
            end
            `IORD_PORT_G_INPUT_PINS: begin
                d = '{kind: kind_pin, mask: `IORD_MASK_PORT_G_PINS};
            end
            `IORD_PORT_A_DIRECTION, `IORD_PORT_A_OUTPUT,
            `IORD_PORT_B_DIRECTION, `IORD_PORT_B_OUTPUT,
            `IORD_PORT_C_DIRECTION, `IORD_PORT_C_OUTPUT,
            `IORD_PORT_D_DIRECTION, `IORD_PORT_D_OUTPUT,
            `IORD_PORT_E_DIRECTION, `IORD_PORT_E_OUTPUT,
            `IORD_PORT_F_DIRECTION, `IORD_PORT_F_OUTPUT,
            `IORD_EEPROM_DATA, `IORD_EEPROM_ADDRESS_LOW,
            `IORD_SCRATCH_BYTE_0, `IORD_TIMER0_CONTROL,
            `IORD_TIMER0_COUNT, `IORD_STACK_POINTER_LOW: begin
                d = '{kind: kind_rw, mask: `IORD_MASK_FULL};
            end
            `IORD_PORT_G_DIRECTION, `IORD_PORT_G_OUTPUT: begin
                d = '{kind: kind_rw, mask: `IORD_MASK_PORT_G};
            end
            `IORD_EXTERNAL_IRQ_MASK: begin
                d = '{kind: kind_rw, mask: `IORD_MASK_EXT_IRQ};
            end
            `IORD_EEPROM_CONTROL: begin
                d = '{kind: kind_rw, mask: `IORD_MASK_EEPROM_CONTROL};
            end
            `IORD_EEPROM_ADDRESS_HIGH: begin
                d = '{kind: kind_rw, mask: `IORD_MASK_EEPROM_ADDR_HI};
            end
            `IORD_TIMER_GENERAL_CTRL: begin
                d = '{kind: kind_rw, mask: `IORD_MASK_TIMER_GENERAL};
            end
            `IORD_SELF_PROGRAM_CONTROL: begin
                d = '{kind: kind_rw, mask: `IORD_MASK_SELF_PROGRAM};
            end
            `IORD_TIMER0_FLAGS: begin
                d = '{kind: kind_w1c, mask: `IORD_MASK_TIMER0_FLAGS};
            end
            `IORD_TIMER1_FLAGS: begin
                d = '{kind: kind_w1c, mask: `IORD_MASK_TIMER1_FLAGS};
            end
            `IORD_TIMER2_FLAGS: begin
                d = '{kind: kind_w1c, mask: `IORD_MASK_TIMER2_FLAGS};
            end
            `IORD_EXTERNAL_IRQ_FLAGS: begin
                d = '{kind: kind_w1c, mask: `IORD_MASK_EXT_IRQ};
            end
            default: begin
                d = '{kind: kind_none, mask: 8'h00};
            end
        endcase
        return d;
    endfunction

    function automatic logic is_bit_op(input iord_op_t op);
        return (op == set_io_bit_op) || (op == clear_io_bit_op) ||
               (op == skip_if_io_bit_set_op) || (op == skip_if_io_bit_clear_op);
    endfunction

    function automatic logic is_data_op(input iord_op_t op);
        return (op == load_direct_op) || (op == store_direct_op);
    endfunction

    // ============================================================
    // Register storage
    logic [7:0]       io_q [64];
    logic [6:0][7:0]  pin_s1;
    logic [6:0][7:0]  pin_s2;
    logic [6:0][7:0]  pin_s3;

    // ============================================================
    // Request decode
    logic             req_fire;
    logic             io_hit;
    logic             ext_hit;
    logic [5:0]       io_addr;
    logic [7:0]       data_off;
    iord_dec_t        cur_dec;
    logic [7:0]       cur_byte;
    logic [7:0]       rd_now;
    logic             wr_en;
    logic [7:0]       wr_bits;
    logic [7:0]       wr_val;
    logic             skip_now;

    assign req_fire = req_i.valid;
    assign data_off = req_i.addr - `IORD_DATA_IO_BASE;

    always_comb begin
        io_hit  = 1'b0;
        ext_hit = 1'b0;
        io_addr = req_i.addr[5:0];
        if (req_i.op == in_op || req_i.op == out_op) begin
            io_hit = 1'b1;
        end else if (is_bit_op(req_i.op)) begin
            io_hit = (req_i.addr <= `IORD_BIT_OP_LAST);
        end else if (req_i.addr >= `IORD_DATA_EXT_BASE) begin
            ext_hit = 1'b1;
        end else if (req_i.addr >= `IORD_DATA_IO_BASE) begin
            io_hit  = 1'b1;
            io_addr = data_off[5:0];
        end
    end

    assign cur_dec  = io_decode(io_addr);
    assign cur_byte = io_q[io_addr];
    // Unused locations and reserved bits answer zero
    assign rd_now   = io_hit ? (cur_byte & cur_dec.mask) : 8'h00;

    assign wr_en = req_fire && io_hit &&
                   (req_i.op == out_op || req_i.op == store_direct_op ||
                    req_i.op == set_io_bit_op || req_i.op == clear_io_bit_op);

    // Bit operations touch one bit only
    always_comb begin
        if (req_i.op == set_io_bit_op || req_i.op == clear_io_bit_op) begin
            wr_bits = 8'h01 << req_i.bit_sel;
            wr_val  = (req_i.op == set_io_bit_op) ? 8'hff : 8'h00;
        end else begin
            wr_bits = 8'hff;
            wr_val  = req_i.wdata;
        end
    end

    // Gated by the hit so a refused bit test never skips
    assign skip_now = io_hit && ((req_i.op == skip_if_io_bit_set_op) ?
                      rd_now[req_i.bit_sel] :
                      ((req_i.op == skip_if_io_bit_clear_op) &&
                       !rd_now[req_i.bit_sel]));

    // ============================================================
    // Pin synchronisers, three stages per port
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
        end else begin
            pin_s1 <= pin_i;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // ============================================================
    // Per-location register behaviour
    genvar gi;
    generate
        for (gi = 0; gi < 64; gi++) begin : g_loc
            localparam iord_dec_t DEC = io_decode(6'(gi));
            logic       hit;
            logic [7:0] hw_set;
            assign hit = wr_en && (io_addr == 6'(gi));
            if (6'(gi) == `IORD_TIMER0_FLAGS) begin : g_t0
                assign hw_set = flag_set_i.timer0;
            end else if (6'(gi) == `IORD_TIMER1_FLAGS) begin : g_t1
                assign hw_set = flag_set_i.timer1;
            end else if (6'(gi) == `IORD_TIMER2_FLAGS) begin : g_t2
                assign hw_set = flag_set_i.timer2;
            end else if (6'(gi) == `IORD_EXTERNAL_IRQ_FLAGS) begin : g_ei
                assign hw_set = flag_set_i.ext_irq;
            end else begin : g_no
                assign hw_set = 8'h00;
            end

            if (DEC.kind == kind_pin) begin : g_pin
                localparam int PK = gi / 3;
                // Pin value moves only when stages two and three agree
                always_ff @(posedge clock_i) begin
                    if (reset_i) begin
                        io_q[gi] <= `IORD_RESET_VALUE;
                    end else begin
                        for (int b = 0; b < 8; b++) begin
                            if (pin_s2[PK][b] == pin_s3[PK][b]) begin
                                io_q[gi][b] <= pin_s3[PK][b] & DEC.mask[b];
                            end
                        end
                    end
                end
            end else if (DEC.kind == kind_rw) begin : g_rw
                always_ff @(posedge clock_i) begin
                    if (reset_i) begin
                        io_q[gi] <= `IORD_RESET_VALUE;
                    end else if (hit) begin
                        io_q[gi] <= ((io_q[gi] & ~wr_bits) | (wr_val & wr_bits))
                                    & DEC.mask;
                    end
                end
            end else if (DEC.kind == kind_w1c) begin : g_w1c
                logic [7:0] clr;
                assign clr = hit ? (wr_val & wr_bits) : 8'h00;
                // Hardware set wins over a clear in the same cycle
                always_ff @(posedge clock_i) begin
                    if (reset_i) begin
                        io_q[gi] <= `IORD_RESET_VALUE;
                    end else begin
                        io_q[gi] <= ((io_q[gi] & ~clr) | hw_set) & DEC.mask;
                    end
                end
            end else begin : g_none
                // Unused location holds zero; writes have no effect
                always_ff @(posedge clock_i) begin
                    io_q[gi] <= 8'h00;
                end
            end
        end
    endgenerate

    // ============================================================
    // Port outputs
    genvar gk;
    generate
        for (gk = 0; gk < `IORD_PORT_COUNT; gk++) begin : g_port
            assign port_dir_o[gk] = io_q[3 * gk + 1];
            assign port_out_o[gk] = io_q[3 * gk + 2];
        end
    endgenerate

    // ============================================================
    // Answer pipeline, stage one
    logic        s1_valid;
    logic        s1_ext;
    logic [7:0]  s1_rdata;
    logic        s1_skip;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            s1_valid <= 1'b0;
            s1_ext   <= 1'b0;
            s1_rdata <= 8'h00;
            s1_skip  <= 1'b0;
        end else begin
            s1_valid <= req_fire;
            s1_ext   <= req_fire && ext_hit && (req_i.op == load_direct_op);
            s1_rdata <= rd_now;
            s1_skip  <= req_fire && skip_now;
        end
    end

    // ============================================================
    // Extended bus strobe, one cycle
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            ext_o <= '0;
        end else begin
            ext_o.sel   <= req_fire && ext_hit && is_data_op(req_i.op);
            ext_o.we    <= req_fire && ext_hit && (req_i.op == store_direct_op);
            ext_o.addr  <= req_i.addr;
            ext_o.wdata <= req_i.wdata;
        end
    end

    // ============================================================
    // Answer pipeline, stage two
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            resp_o <= '0;
        end else begin
            resp_o.valid <= s1_valid;
            resp_o.rdata <= s1_ext ? ext_rdata_i : s1_rdata;
            resp_o.skip  <= s1_skip;
        end
    end

    // ============================================================
    // Checks
    logic [7:0] hw_set_any;
    assign hw_set_any = flag_set_i.timer0 | flag_set_i.timer1
                      | flag_set_i.timer2 | flag_set_i.ext_irq;

    a_bit_set_rw:
    assert property (@(posedge clock_i) disable iff (reset_i)
        req_fire && req_i.op == set_io_bit_op && io_hit && cur_dec.kind == kind_rw
        && cur_dec.mask[req_i.bit_sel]
        |=> io_q[$past(io_addr)][$past(req_i.bit_sel)] == 1'b1)
    else $error("bit set did not set the addressed bit");

    a_skip_answer:
    assert property (@(posedge clock_i) disable iff (reset_i)
        req_fire |-> ##2 (resp_o.valid && resp_o.skip == $past(skip_now, 2)))
    else $error("skip answer does not match tested bit");

    a_w1c_zero_keeps:
    assert property (@(posedge clock_i) disable iff (reset_i)
        wr_en && cur_dec.kind == kind_w1c && (wr_val & wr_bits) == 8'h00
        |=> ($past(cur_byte) & ~io_q[$past(io_addr)]) == 8'h00)
    else $error("writing zero to a flag register lost a flag");

    a_w1c_single_bit:
    assert property (@(posedge clock_i) disable iff (reset_i)
        wr_en && req_i.op == set_io_bit_op && cur_dec.kind == kind_w1c
        |=> ((io_q[$past(io_addr)] ^ $past(cur_byte))
             & ~$past(wr_bits) & ~$past(hw_set_any)) == 8'h00)
    else $error("bit operation disturbed another flag");

    a_high_bit_op:
    assert property (@(posedge clock_i) disable iff (reset_i)
        req_fire && is_bit_op(req_i.op) && req_i.addr > `IORD_BIT_OP_LAST
        |-> !wr_en ##2 (resp_o.rdata == 8'h00 && !resp_o.skip))
    else $error("bit operation decoded above the low range");

    a_out_writes:
    assert property (@(posedge clock_i) disable iff (reset_i)
        req_fire && req_i.op == out_op && cur_dec.kind == kind_rw
        |=> io_q[$past(io_addr)] == ($past(req_i.wdata) & $past(cur_dec.mask)))
    else $error("output operation did not store the byte");

    a_data_map:
    assert property (@(posedge clock_i) disable iff (reset_i)
        req_fire && req_i.op == load_direct_op
        && req_i.addr >= `IORD_DATA_IO_BASE && req_i.addr <= `IORD_DATA_IO_LAST
        |-> ##2 resp_o.rdata == $past(io_q[data_off[5:0]] & cur_dec.mask, 2))
    else $error("data-space load hit the wrong register");

    a_ext_only_data:
    assert property (@(posedge clock_i) disable iff (reset_i)
        ext_o.sel |-> $past(is_data_op(req_i.op)) && $past(req_i.addr)
                      >= `IORD_DATA_EXT_BASE)
    else $error("extended space reached by a non data access");

    a_unused_zero:
    assert property (@(posedge clock_i) disable iff (reset_i)
        req_fire && io_hit && cur_dec.kind == kind_none
        |-> ##2 resp_o.rdata == 8'h00)
    else $error("unused location returned nonzero data");

endmodule

// ===== hw/iord_map.svh
// Purpose: Offsets, field masks, reset value and limits of the I/O register space
// Assumes: I/O addresses are 6 bits; data-space addresses are 8 bits
// Notes:   Masks mark implemented bits; all other bits read as zero
`ifndef IORD_MAP_SVH
`define IORD_MAP_SVH

// ============================================================
// I/O register offsets
`define IORD_PORT_A_INPUT_PINS    6'h00
`define IORD_PORT_A_DIRECTION     6'h01
`define IORD_PORT_A_OUTPUT        6'h02
`define IORD_PORT_B_INPUT_PINS    6'h03
`define IORD_PORT_B_DIRECTION     6'h04
`define IORD_PORT_B_OUTPUT        6'h05
`define IORD_PORT_C_INPUT_PINS    6'h06
`define IORD_PORT_C_DIRECTION     6'h07
`define IORD_PORT_C_OUTPUT        6'h08
`define IORD_PORT_D_INPUT_PINS    6'h09
`define IORD_PORT_D_DIRECTION     6'h0a
`define IORD_PORT_D_OUTPUT        6'h0b
`define IORD_PORT_E_INPUT_PINS    6'h0c
`define IORD_PORT_E_DIRECTION     6'h0d
`define IORD_PORT_E_OUTPUT        6'h0e
`define IORD_PORT_F_INPUT_PINS    6'h0f
`define IORD_PORT_F_DIRECTION     6'h10
`define IORD_PORT_F_OUTPUT        6'h11
`define IORD_PORT_G_INPUT_PINS    6'h12
`define IORD_PORT_G_DIRECTION     6'h13
`define IORD_PORT_G_OUTPUT        6'h14
`define IORD_TIMER0_FLAGS         6'h15
`define IORD_TIMER1_FLAGS         6'h16
`define IORD_TIMER2_FLAGS         6'h17
`define IORD_EXTERNAL_IRQ_FLAGS   6'h1c
`define IORD_EXTERNAL_IRQ_MASK    6'h1d
`define IORD_SCRATCH_BYTE_0       6'h1e
`define IORD_EEPROM_CONTROL       6'h1f
`define IORD_EEPROM_DATA          6'h20
`define IORD_EEPROM_ADDRESS_LOW   6'h21
`define IORD_EEPROM_ADDRESS_HIGH  6'h22
`define IORD_TIMER_GENERAL_CTRL   6'h23
`define IORD_TIMER0_CONTROL       6'h24
`define IORD_TIMER0_COUNT         6'h26
`define IORD_SELF_PROGRAM_CONTROL 6'h37
`define IORD_STACK_POINTER_LOW    6'h3d

// ============================================================
// Implemented-bit masks
`define IORD_MASK_FULL            8'hff
`define IORD_MASK_PORT_G_PINS     8'h3f
`define IORD_MASK_PORT_G          8'h1f
`define IORD_MASK_TIMER0_FLAGS    8'h03
`define IORD_MASK_TIMER1_FLAGS    8'h27
`define IORD_MASK_TIMER2_FLAGS    8'h03
`define IORD_MASK_EXT_IRQ         8'hf1
`define IORD_MASK_EEPROM_CONTROL  8'h0f
`define IORD_MASK_EEPROM_ADDR_HI  8'h07
`define IORD_MASK_TIMER_GENERAL   8'h83
`define IORD_MASK_SELF_PROGRAM    8'hdf

// ============================================================
// Reset value and address limits
`define IORD_RESET_VALUE          8'h00
`define IORD_BIT_OP_LAST          8'h1f
`define IORD_DATA_IO_BASE         8'h20
`define IORD_DATA_IO_LAST         8'h5f
`define IORD_DATA_EXT_BASE        8'h60
`define IORD_PORT_COUNT           7

`endif

// ===== hw/iord_pkg.sv
// Purpose: Types shared by the I/O register space decoder
// Assumes: Offsets and masks come from iord_map.svh
// Notes:   Request and answer groups travel as packed structs
package iord_pkg;

    // ============================================================
    // Access kinds issued by the core
    typedef enum logic [2:0] {
        in_op                   = 3'b000,
        out_op                  = 3'b001,
        set_io_bit_op           = 3'b010,
        clear_io_bit_op         = 3'b011,
        skip_if_io_bit_set_op   = 3'b100,
        skip_if_io_bit_clear_op = 3'b101,
        load_direct_op          = 3'b110,
        store_direct_op         = 3'b111
    } iord_op_t;

    // ============================================================
    // Register behaviour classes
    typedef enum logic [1:0] {
        kind_none = 2'b00,
        kind_pin  = 2'b01,
        kind_rw   = 2'b10,
        kind_w1c  = 2'b11
    } iord_kind_t;

    typedef struct packed {
        iord_kind_t  kind;
        logic [7:0]  mask;
    } iord_dec_t;

    typedef struct packed {
        logic        valid;
        iord_op_t    op;
        logic [7:0]  addr;
        logic [2:0]  bit_sel;
        logic [7:0]  wdata;
    } iord_req_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  rdata;
        logic        skip;
    } iord_resp_t;

    typedef struct packed {
        logic        sel;
        logic        we;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } iord_ext_t;

    typedef struct packed {
        logic [7:0]  timer0;
        logic [7:0]  timer1;
        logic [7:0]  timer2;
        logic [7:0]  ext_irq;
    } iord_flag_set_t;

endpackage

// ===== test/iord_core_model.sv
// Purpose: Core-side model: issues requests, serves the extended bus
// Assumes: Answer comes two edges after the taking edge
// Notes:   Idle extended data shows the inverse of the last value
`timescale 1ns/100ps
module iord_core_model (
    // Clock
    input  wire logic                 clock_i,
    // Request and answer
    output iord_pkg::iord_req_t       req_o,
    input  wire iord_pkg::iord_resp_t resp_i,
    // Extended bus
    input  wire iord_pkg::iord_ext_t  ext_i,
    output logic [7:0]                ext_rdata_o
);
    import iord_pkg::*;
    logic [7:0] last_q = 8'h00;

    // ============================================================
    // Request driver
    initial begin
        req_o = '0;
    end

    task automatic access(input iord_op_t op, input logic [7:0] addr,
                          input logic [2:0] bsel, input logic [7:0] wdata,
                          output iord_resp_t resp);
        @(posedge clock_i);
        #1;
        req_o = '{1'b1, op, addr, bsel, wdata}; // Callers pass clean data
        @(posedge clock_i);
        #1;
        req_o = '0;
        // Answer is read while it stands, before the next edge
        @(posedge clock_i);
        #1;
        resp = resp_i;
    endtask

    // ============================================================
    // Extended responder
    assign ext_rdata_o = ext_i.sel ? (ext_i.addr ^ 8'h5a) : ~last_q;

    always @(posedge clock_i) begin
        last_q <= ext_rdata_o;
    end
endmodule

// ===== test/iord_space_tb.sv
// Purpose: Self-checking bench of the I/O register space
// Assumes: Core model drives requests; bench drives pins and flags
// Notes:   Table rows first, then flags, pins and reset by hand
`timescale 1ns/100ps
module iord_space_tb;
    import iord_pkg::*;
    typedef struct packed {
        iord_op_t    op;
        logic [7:0]  addr;
        logic [2:0]  bsel;
        logic [7:0]  wdata;
        logic [7:0]  exp_d;
        logic        exp_s;
    } iord_row_t;

    logic             clock_i = 1'b0;
    logic             reset_i = 1'b1;
    iord_req_t        req;
    iord_resp_t       resp;
    iord_resp_t       r;
    logic [6:0][7:0]  pin_i = '0;
    logic [6:0][7:0]  port_out;
    logic [6:0][7:0]  port_dir;
    iord_flag_set_t   flag_set_i = '0;
    iord_ext_t        ext;
    logic [7:0]       ext_rdata;
    int               err_total = 0;
    int               checked = 0;
    int               cycles = 0;
    int               ext_cnt = 0;
    iord_row_t        rows [20] = '{
        '{out_op, 8'h05, 3'h0, 8'h5a, 8'h00, 1'b0},
        '{in_op, 8'h05, 3'h0, 8'h00, 8'h5a, 1'b0},
        '{store_direct_op, 8'h21, 3'h0, 8'ha5, 8'h00, 1'b0},
        '{in_op, 8'h01, 3'h0, 8'h00, 8'ha5, 1'b0},
        '{load_direct_op, 8'h25, 3'h0, 8'h00, 8'h5a, 1'b0},
        '{set_io_bit_op, 8'h05, 3'h0, 8'h00, 8'h00, 1'b0},
        '{clear_io_bit_op, 8'h05, 3'h6, 8'h00, 8'h00, 1'b0},
        '{in_op, 8'h05, 3'h0, 8'h00, 8'h1b, 1'b0},
        '{skip_if_io_bit_set_op, 8'h05, 3'h3, 8'h00, 8'h00, 1'b1},
        '{skip_if_io_bit_clear_op, 8'h05, 3'h3, 8'h00, 8'h00, 1'b0},
        '{skip_if_io_bit_clear_op, 8'h05, 3'h2, 8'h00, 8'h00, 1'b1},
        '{out_op, 8'h3d, 3'h0, 8'h77, 8'h00, 1'b0},
        '{load_direct_op, 8'h5d, 3'h0, 8'h00, 8'h77, 1'b0},
        '{set_io_bit_op, 8'h22, 3'h0, 8'h00, 8'h00, 1'b0},
        '{in_op, 8'h22, 3'h0, 8'h00, 8'h00, 1'b0},
        '{in_op, 8'h1b, 3'h0, 8'h00, 8'h00, 1'b0},
        '{store_direct_op, 8'h80, 3'h0, 8'h33, 8'h00, 1'b0},
        '{load_direct_op, 8'h80, 3'h0, 8'h00, 8'hda, 1'b0},
        '{in_op, 8'h20, 3'h0, 8'h00, 8'h00, 1'b0},
        '{skip_if_io_bit_clear_op, 8'h22, 3'h0, 8'h00, 8'h00, 1'b0}
    };

    iord_space dut_u (
        .clock_i(clock_i), .reset_i(reset_i), .req_i(req), .resp_o(resp),
        .pin_i(pin_i), .port_out_o(port_out), .port_dir_o(port_dir),
        .flag_set_i(flag_set_i), .ext_o(ext), .ext_rdata_i(ext_rdata)
    );

    iord_core_model core_u (
        .clock_i(clock_i), .req_o(req), .resp_i(resp),
        .ext_i(ext), .ext_rdata_o(ext_rdata)
    );

    // ============================================================
    // Clock, timeout, extended bus watch
    initial begin
        forever #5 clock_i = ~clock_i;
    end

    always @(posedge clock_i) begin
        cycles++;
        if (ext.sel === 1'b1) ext_cnt++;
        if (cycles == 1000) begin
            err_total++;
            close_out();
        end
    end

    // ============================================================
    // Checking helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic io(input iord_op_t op, input logic [7:0] a, input logic [2:0] b,
                      input logic [7:0] w);
        core_u.access(op, a, b, w, r);
    endtask

    task automatic close_out();
        if (err_total == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ============================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge clock_i);
        #1;
        reset_i = 1'b0;
        foreach (rows[i]) begin
            io(rows[i].op, rows[i].addr, rows[i].bsel, rows[i].wdata);
            check({7'h0, r.valid}, 8'h01);
            if (rows[i].op inside {in_op, load_direct_op})
                check(r.rdata, rows[i].exp_d);
            if (rows[i].op inside {skip_if_io_bit_set_op, skip_if_io_bit_clear_op})
                check({7'h0, r.skip}, {7'h0, rows[i].exp_s});
        end
        check(8'(ext_cnt), 8'h02);
        check(port_out[1], 8'h1b);
        check(port_dir[0], 8'ha5);
        // Flag set, byte write of zero, single-bit clear, byte write-one
        @(posedge clock_i);
        #1;
        flag_set_i.timer1 = 8'hff;
        @(posedge clock_i);
        #1;
        flag_set_i = '0;
        io(in_op, 8'h16, 3'h0, 8'h00);
        check(r.rdata, 8'h27);
        io(out_op, 8'h16, 3'h0, 8'h00);
        io(in_op, 8'h16, 3'h0, 8'h00);
        check(r.rdata, 8'h27);
        io(set_io_bit_op, 8'h16, 3'h1, 8'h00);
        io(in_op, 8'h16, 3'h0, 8'h00);
        check(r.rdata, 8'h25);
        io(out_op, 8'h16, 3'h0, 8'h04);
        io(in_op, 8'h16, 3'h0, 8'h00);
        check(r.rdata, 8'h21);
        // Pins through the synchroniser
        pin_i[2] = 8'h96;
        repeat (5) @(posedge clock_i);
        io(in_op, 8'h06, 3'h0, 8'h00);
        check(r.rdata, 8'h96);
        io(skip_if_io_bit_set_op, 8'h06, 3'h1, 8'h00);
        check({7'h0, r.skip}, 8'h01);
        // Mid-run reset
        reset_i = 1'b1;
        repeat (3) @(posedge clock_i);
        #1;
        reset_i = 1'b0;
        check(port_out[1], 8'h00);
        io(in_op, 8'h05, 3'h0, 8'h00);
        check(r.rdata, 8'h00);
        close_out();
    end
endmodule
